// file: ufic_pkg.sv
// Constants for the FIFO control and interrupt identification block.
// Assumes an 8-bit register port on one clock; offsets are byte offsets.
package ufic_pkg;

  // Register offsets within the port window
  localparam logic [2:0] OFF_DATA       = 3'h0; // Receive read, transmit write
  localparam logic [2:0] OFF_IDENT      = 3'h2; // Ident read, fifo setup write
  localparam logic [2:0] OFF_LINE_STAT  = 3'h5; // Read clears line status event
  localparam logic [2:0] OFF_MODEM_STAT = 3'h6; // Read clears modem event

  // Queue geometry
  localparam int          QUEUE_DEPTH = 16;
  localparam int          PTR_W       = 4;
  localparam int          CNT_W       = 5;
  localparam logic [4:0]  CAP_FIFO    = 5'h10;
  localparam logic [4:0]  CAP_SINGLE  = 5'h01;
  localparam logic [1:0]  TXBUF_SLOTS = 2'h2;

  // fifo_setup_control field positions
  localparam int FSC_ENABLE_BIT   = 0;
  localparam int FSC_RX_FLUSH_BIT = 1;
  localparam int FSC_TX_FLUSH_BIT = 2;
  localparam int FSC_DMA_BIT      = 3;
  localparam int FSC_TRIG_LSB     = 6;

  // fifo_setup_control reset values
  localparam logic       FIFO_EN_RST = 1'b0;
  localparam logic [1:0] TRIG_RST    = 2'h0;

  // Receive trigger levels in bytes, indexed by the trigger field
  localparam logic [4:0] TRIG_LVL_0 = 5'h01;
  localparam logic [4:0] TRIG_LVL_1 = 5'h04;
  localparam logic [4:0] TRIG_LVL_2 = 5'h08;
  localparam logic [4:0] TRIG_LVL_3 = 5'h0E;

  // Interrupt enable input bit positions
  localparam int IEN_RX_DATA = 0;
  localparam int IEN_TX_EMPTY = 1;
  localparam int IEN_LINE    = 2;
  localparam int IEN_MODEM   = 3;

  // interrupt_source_ident source codes for bits 2:1
  localparam logic [1:0] ID_LINE     = 2'h3;
  localparam logic [1:0] ID_RX_DATA  = 2'h2;
  localparam logic [1:0] ID_TX_EMPTY = 2'h1;
  localparam logic [1:0] ID_MODEM    = 2'h0;

  // Character timeout length in character times
  localparam logic [2:0] TIMEOUT_CHARS = 3'h4;

endpackage

// file: ufic_queue.sv
// Sixteen-entry byte queue with flush and a registered read port.
// Assumes the caller never pushes when full nor pops when empty.
`timescale 1ns/1ps
`default_nettype none
module ufic_queue
(
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    arst_n,
  input  wire logic                    ce,
  // Control
  input  wire logic                    flush,
  input  wire logic                    push,
  input  wire logic [7:0]              push_data,
  input  wire logic                    pop,
  // Status and data
  output logic      [7:0]              pop_data,
  output logic      [ufic_pkg::CNT_W-1:0] level
);

  typedef struct packed {
    logic [ufic_pkg::QUEUE_DEPTH-1:0][7:0] mem;
    logic [ufic_pkg::PTR_W-1:0]            wp;
    logic [ufic_pkg::PTR_W-1:0]            rp;
    logic [ufic_pkg::CNT_W-1:0]            cnt;
    logic [7:0]                            q;
  } ufic_queue_st_t;

  ufic_queue_st_t st_reg;
  ufic_queue_st_t st_next;

  // Next state; flush wins over a push in the same cycle
  always_comb
  begin
    st_next = st_reg;
    if (pop)
    begin
      st_next.q  = st_reg.mem[st_reg.rp];
      st_next.rp = st_reg.rp + 4'h1;
    end
    if (push)
    begin
      st_next.mem[st_reg.wp] = push_data;
      st_next.wp             = st_reg.wp + 4'h1;
    end
    st_next.cnt = st_reg.cnt + {4'h0, push} - {4'h0, pop};
    if (flush)
    begin
      st_next.wp  = '0;
      st_next.rp  = '0;
      st_next.cnt = '0; // Counter back to zero
    end
  end

  // State register; the storage is reset too, so no stale byte leaks out
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      st_reg <= '0;
    else if (ce)
      st_reg <= st_next;
  end

  assign pop_data = st_reg.q;
  assign level    = st_reg.cnt;

endmodule
`default_nettype wire

// file: ufic_top.sv
// FIFO control and interrupt identification for a byte-wide serial port.
// Assumes the register port, receiver, transmitter and event sources
// all run on ref_clk; enables come from an interrupt enable register.
// The line and modem status registers live outside this block; only
// their read strobes are seen here, so reads of them return zero.
// Masking a source through int_enable masks the ident value as well,
// so bit 0 then reads one whatever event is stored.
//
// Operation
// - Enable bit one turns both queues on; zero turns off and empties both.
// - Receive flush bit empties receive queue, zeroes count, self-clears.
// - Transmit flush bit empties transmit queue, zeroes count, self-clears.
// - DMA select bit is stored without effect; bits 4 and 5 reserved.
// - Top two setup bits choose receive threshold of 1, 4, 8 or 14.
// - Priority: line status, received data or timeout, transmit empty, modem.
// - Identification value is frozen while the host reads it.
// - Ident bit 0 is zero when an enabled interrupt is pending.
// - Ident bits 2:1 give 11 line, 10 data, 01 transmit, 00 modem.
// - Ident bit 3 is set with bit 2 for timeout in FIFO mode.
// - Ident bits 4 and 5 always read zero.
// - Ident bits 7:6 read ones while the queues are enabled.
// - Line errors raise line status event; line status read clears it.
// - Data event follows threshold; falls when reads drop level below it.
// - Timeout when queue holds data, idle four character times; read clears.
// - Transmit empty cleared by ident read reporting it or a data write.
// - Modem input changes raise modem event; modem status read clears it.
`timescale 1ns/1ps
`default_nettype none
module ufic_top
(
  // Clock, reset and clock enable
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  // Host register port
  input  wire logic [2:0] reg_addr,
  input  wire logic       reg_rd,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_ack,
  // Interrupt enables from the enable register
  input  wire logic [3:0] int_enable,
  // Receiver byte stream into the receive queue
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  output logic            rx_ready,
  // Transmit byte stream toward the shifter
  output logic            tx_valid,
  output logic      [7:0] tx_data,
  input  wire logic       tx_ready,
  // Event sources
  input  wire logic [3:0] line_err,
  input  wire logic [3:0] modem_change,
  input  wire logic       char_tick,
  // Status
  output logic            fifo_mode,
  output logic            intr_pending
);

  // Controller state; one copy registered, one copy computed
  typedef struct packed {
    // Setup register fields
    logic       fifo_en;
    logic       dma_sel;
    logic [1:0] trig;
    // Event flags and their edge history
    logic       line_pend;
    logic       modem_pend;
    logic       thre_pend;
    logic       tx_empty_d;
    logic       thre_en_d;
    logic [2:0] idle_chars;
    // Register port answer
    logic [7:0] rdata;
    logic       rd_from_rx;
    logic       ack;
    logic       intr;
    // Two-slot transmit buffer
    logic [1:0] buf_cnt;
    logic       inflight;
    logic [7:0] buf0;
    logic [7:0] buf1;
  } ufic_st_t;

  ufic_st_t st_reg;
  ufic_st_t st_next;

  // Queue wiring; levels run from 0 to 16, so they need five bits
  logic                      rx_flush;
  logic                      tx_flush;
  logic                      rx_push;
  logic                      rx_pop;
  logic                      tx_push;
  logic                      tx_pop;
  logic [7:0]                rx_q;
  logic [7:0]                tx_q;
  logic [ufic_pkg::CNT_W-1:0] rx_lvl;
  logic [ufic_pkg::CNT_W-1:0] tx_lvl;

  // Decode and event terms
  logic       setup_wr;
  logic       data_rd;
  logic       ident_rd;
  logic [4:0] cap;
  logic [4:0] trig_lvl;
  logic       data_avail;
  logic       timeout;
  logic       p_line;
  logic       p_data;
  logic       p_to;
  logic       p_thre;
  logic       p_modem;
  logic [7:0] ident;
  logic       tx_empty;
  logic       thre_rise;
  logic       buf_take;
  logic [1:0] buf_after;

  // Receive queue, fed by the receiver stream and popped by data reads
  ufic_queue u_rx_queue
  (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .ce        (ce),
    .flush     (rx_flush),
    .push      (rx_push),
    .push_data (rx_data),
    .pop       (rx_pop),
    .pop_data  (rx_q),
    .level     (rx_lvl)
  );

  // Transmit queue, fed by data writes and drained into the buffer
  ufic_queue u_tx_queue
  (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .ce        (ce),
    .flush     (tx_flush),
    .push      (tx_push),
    .push_data (reg_wdata),
    .pop       (tx_pop),
    .pop_data  (tx_q),
    .level     (tx_lvl)
  );

  // Access decode; everything is gated by the clock enable
  // Data reads and writes share offset 0, ident and setup share 2
  always_comb
  begin
    setup_wr = ce && reg_wr && (reg_addr == ufic_pkg::OFF_IDENT);
    data_rd  = ce && reg_rd && (reg_addr == ufic_pkg::OFF_DATA);
    ident_rd = ce && reg_rd && (reg_addr == ufic_pkg::OFF_IDENT);
  end

  // Flushes are single-cycle strobes, so the flush bits are never stored
  // A disable write flushes both queues whatever the flush bits say
  always_comb
  begin
    rx_flush = setup_wr && (!reg_wdata[ufic_pkg::FSC_ENABLE_BIT]
               || reg_wdata[ufic_pkg::FSC_RX_FLUSH_BIT]);
    tx_flush = setup_wr && (!reg_wdata[ufic_pkg::FSC_ENABLE_BIT]
               || reg_wdata[ufic_pkg::FSC_TX_FLUSH_BIT]);
  end

  // Without FIFO mode each queue behaves as a one-byte holding register
  // Room is refused in a flush cycle; the source just holds its byte
  always_comb
  begin
    cap = st_reg.fifo_en ? ufic_pkg::CAP_FIFO : ufic_pkg::CAP_SINGLE;
    rx_ready = ce && !rx_flush && (rx_lvl < cap);
    rx_push  = rx_valid && rx_ready;
    rx_pop   = data_rd && (rx_lvl != 5'h00);
    // A write to a full holding queue is dropped rather than corrupting it
    tx_push  = ce && reg_wr && (reg_addr == ufic_pkg::OFF_DATA)
               && !tx_flush && (tx_lvl < cap);
  end

  // Receive threshold lookup
  // The default branch only catches an unknown field value
  always_comb
  begin
    case (st_reg.trig)
      2'h0:    trig_lvl = ufic_pkg::TRIG_LVL_0;
      2'h1:    trig_lvl = ufic_pkg::TRIG_LVL_1;
      2'h2:    trig_lvl = ufic_pkg::TRIG_LVL_2;
      2'h3:    trig_lvl = ufic_pkg::TRIG_LVL_3;
      default: trig_lvl = ufic_pkg::TRIG_LVL_0;
    endcase
  end

  // Enabled pending sources; data event is a level, so it drops by itself
  // Timeout shares the data enable bit, as the enable register defines
  always_comb
  begin
    data_avail = st_reg.fifo_en ? (rx_lvl >= trig_lvl)
                                : (rx_lvl != 5'h00);
    timeout = st_reg.fifo_en && (rx_lvl != 5'h00)
              && (st_reg.idle_chars == ufic_pkg::TIMEOUT_CHARS);
    p_line  = st_reg.line_pend  && int_enable[ufic_pkg::IEN_LINE];
    p_data  = data_avail        && int_enable[ufic_pkg::IEN_RX_DATA];
    p_to    = timeout           && int_enable[ufic_pkg::IEN_RX_DATA];
    p_thre  = st_reg.thre_pend  && int_enable[ufic_pkg::IEN_TX_EMPTY];
    p_modem = st_reg.modem_pend && int_enable[ufic_pkg::IEN_MODEM];
  end

  // Identification value, highest priority source first
  // Bit 0 is set last so that it sees every enabled source
  always_comb
  begin
    ident = 8'h01;
    if (p_line)
      ident[2:1] = ufic_pkg::ID_LINE;
    else if (p_data || p_to)
    begin
      ident[2:1] = ufic_pkg::ID_RX_DATA;
      ident[3]   = p_to && !p_data;
    end
    else if (p_thre)
      ident[2:1] = ufic_pkg::ID_TX_EMPTY;
    else
      ident[2:1] = ufic_pkg::ID_MODEM;
    ident[0]   = !(p_line || p_data || p_to || p_thre || p_modem);
    ident[5:4] = 2'h0;
    ident[7:6] = {2{st_reg.fifo_en}};
  end

  // Transmit drain; credits count the word already on its way out
  // Without counting the in-flight word a third byte could be popped
  // into a full buffer and lost while the shifter stalls
  always_comb
  begin
    tx_empty  = (tx_lvl == 5'h00);
    thre_rise = (tx_empty && !st_reg.tx_empty_d)
                || (tx_empty && int_enable[ufic_pkg::IEN_TX_EMPTY]
                    && !st_reg.thre_en_d);
    buf_take  = tx_valid && tx_ready && ce;
    buf_after = st_reg.buf_cnt - {1'b0, buf_take};
    tx_pop    = ce && !tx_empty && !tx_flush
                && (({1'b0, st_reg.buf_cnt} + {2'h0, st_reg.inflight})
                    < {1'b0, ufic_pkg::TXBUF_SLOTS});
  end

  // Next state of the controller
  always_comb
  begin
    st_next = st_reg;

    // Setup register write; other bits need the enable bit set
    if (setup_wr)
    begin
      st_next.fifo_en = reg_wdata[ufic_pkg::FSC_ENABLE_BIT];
      if (reg_wdata[ufic_pkg::FSC_ENABLE_BIT])
      begin
        st_next.dma_sel = reg_wdata[ufic_pkg::FSC_DMA_BIT];
        st_next.trig    = reg_wdata[ufic_pkg::FSC_TRIG_LSB +: 2];
      end
    end

    // Line and modem events: a new event wins over a clearing read
    // Offsets 5 and 6 are only watched here for their clearing reads
    if (ce && reg_rd && (reg_addr == ufic_pkg::OFF_LINE_STAT))
      st_next.line_pend = 1'b0;
    if (|line_err)
      st_next.line_pend = 1'b1;
    if (ce && reg_rd && (reg_addr == ufic_pkg::OFF_MODEM_STAT))
      st_next.modem_pend = 1'b0;
    if (|modem_change)
      st_next.modem_pend = 1'b1;

    // Transmit empty: cleared by data write or reporting ident read
    if (tx_push || (ident_rd && ident[2:1] == ufic_pkg::ID_TX_EMPTY
                    && !ident[0]))
      st_next.thre_pend = 1'b0;
    if (thre_rise)
      st_next.thre_pend = 1'b1;

    // History for the empty and enable edge detectors
    st_next.tx_empty_d = tx_empty;
    st_next.thre_en_d  = int_enable[ufic_pkg::IEN_TX_EMPTY];

    // Idle counter restarts on any queue movement or when empty
    // It saturates at the limit, so the timeout stays until a read, a push or a flush
    if (rx_push || rx_pop || rx_flush || rx_lvl == 5'h00)
      st_next.idle_chars = 3'h0;
    else if (char_tick && st_reg.idle_chars != ufic_pkg::TIMEOUT_CHARS)
      st_next.idle_chars = st_reg.idle_chars + 3'h1;

    // Read data snapshot; ident is captured at the access edge
    st_next.ack        = ce && (reg_rd || reg_wr);
    st_next.rd_from_rx = data_rd;
    if (ident_rd)
      st_next.rdata = ident;
    else
      st_next.rdata = 8'h00;

    // Interrupt line is the inverse of ident bit 0, one cycle late
    st_next.intr = !ident[0];

    // Two-slot transmit buffer: shift on take, land the in-flight word
    st_next.inflight = tx_pop;
    st_next.buf_cnt  = buf_after;
    if (buf_take)
      st_next.buf0 = st_reg.buf1;
    if (st_reg.inflight)
    begin
      if (buf_after == 2'h0)
        st_next.buf0 = tx_q;
      else
        st_next.buf1 = tx_q;
      st_next.buf_cnt = buf_after + 2'h1;
    end
  end

  // State register with clock enable freezing everything
  // Reset values come from the package where the rules give them
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg            <= '0;
      st_reg.fifo_en    <= ufic_pkg::FIFO_EN_RST;
      st_reg.trig       <= ufic_pkg::TRIG_RST;
      st_reg.tx_empty_d <= 1'b1; // No spurious empty event after reset
    end
    else if (ce)
      st_reg <= st_next;
  end

  // Outputs; read data muxes two flops, the queue word or the snapshot
  // The queue word is already registered, so no extra latency is added
  assign reg_rdata    = st_reg.rd_from_rx ? rx_q : st_reg.rdata;
  assign reg_ack      = st_reg.ack;
  assign tx_valid     = (st_reg.buf_cnt != 2'h0);
  assign tx_data      = st_reg.buf0;
  assign fifo_mode    = st_reg.fifo_en;
  assign intr_pending = st_reg.intr;

endmodule
`default_nettype wire

// file: ufic_properties.sv
// Port-level checks for the FIFO control and ident block.
// Assumes it is bound to ufic_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module ufic_props
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic       ce,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_ack,
  input wire logic [3:0] int_enable,
  // Transmit stream and status
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_ready,
  input wire logic       fifo_mode
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  logic [3:0] last_rd;
  logic [3:0] last_en;
  logic       id_ack;
  // Previous read request and enables, needed in the answer cycle
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      last_rd <= 4'h0;
      last_en <= 4'h0;
    end
    else
    begin
      last_rd <= {ce && reg_rd, reg_addr};
      last_en <= int_enable;
    end
  end
  // Answer cycle of an ident read
  assign id_ack = reg_ack && last_rd == 4'hA;
  chk_ack_follows: assert property ((ce && (reg_rd || reg_wr)) |=> reg_ack)
    else $error("no ack after access");
  chk_ack_only: assert property (reg_ack |-> $past(ce && (reg_rd || reg_wr)))
    else $error("ack without access");
  chk_ident_resv: assert property (id_ack |-> reg_rdata[5:4] == 2'h0)
    else $error("ident bits 5:4 set");
  chk_ident_mode: assert property (
    id_ack |-> reg_rdata[7:6] == {2{fifo_mode}})
    else $error("ident bits 7:6 wrong");
  chk_timeout_code: assert property (
    id_ack && reg_rdata[3] |-> reg_rdata[2:0] == 3'h4 && fifo_mode)
    else $error("ident bit 3 misplaced");
  chk_none_masked: assert property (
    id_ack && last_en == 4'h0 |-> reg_rdata[3:0] == 4'h1)
    else $error("masked source shown");
  chk_mode_write: assert property (
    ce && reg_wr && reg_addr == 3'h2 |=> fifo_mode == $past(reg_wdata[0]))
    else $error("mode not taken");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data))
    else $error("tx byte dropped in stall");
  chk_unmapped_zero: assert property (reg_ack && last_rd[3] &&
    !(last_rd[2:0] inside {3'h0, 3'h2}) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind ufic_top ufic_props props_u (.ref_clk(ref_clk), .arst_n(arst_n),
  .ce(ce), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
  .int_enable(int_enable), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_ready(tx_ready), .fifo_mode(fifo_mode));
`default_nettype wire

// file: ufic_tx_sink.sv
// Model of the transmit shifter that drains the block's byte stream.
// Assumes the bench paces it through stall and slow.
`timescale 1ns/1ps
`default_nettype none
module ufic_tx_sink
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Byte stream from the block
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  // Pacing from the bench
  input  wire logic       stall,
  input  wire logic       slow
);
  logic       phase;
  logic [7:0] got [$];
  // Slow mode takes a byte every other cycle, like a busy shifter
  assign tx_ready = !stall && (!slow || phase);
  // Record every byte taken, in order
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      phase <= 1'b0;
    else
    begin
      phase <= !phase;
      if (tx_valid && tx_ready)
        got.push_back(tx_data);
    end
  end
endmodule
`default_nettype wire

// file: test_uart_fifo_ctrl_int_ident.sv
// Self-checking bench for the FIFO control and ident block.
// Assumes ufic_top, the shifter model and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module test_uart_fifo_ctrl_int_ident;
  logic       ref_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic       reg_rd = 1'b0;
  logic       reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [3:0] int_enable = 4'h0;
  logic       rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic [3:0] line_err = 4'h0;
  logic [3:0] modem_change = 4'h0;
  logic       char_tick = 1'b0;
  logic       stall = 1'b0;
  logic       slow = 1'b0;
  logic       ce = 1'b1;
  logic       rx_ready, tx_valid, tx_ready, fifo_mode, intr_pending, reg_ack;
  logic [7:0] reg_rdata, tx_data, rd;
  logic [4:0] trig [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  int         n_mismatch = 0;
  int         n_tests = 0;
  int         i, k;
  always #10 ref_clk = ~ref_clk;
  // Block under test with the shifter model on its stream side
  ufic_top dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .int_enable(int_enable), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .line_err(line_err), .modem_change(modem_change),
    .char_tick(char_tick), .fifo_mode(fifo_mode),
    .intr_pending(intr_pending));
  ufic_tx_sink sink_u (.ref_clk(ref_clk), .arst_n(arst_n),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .stall(stall), .slow(slow));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One access; the ack is due exactly one cycle after the strobe
  task automatic acc(input logic wr, input logic [2:0] a,
                     input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd = reg_rdata;
    check("ack", 8'h01, {7'h00, reg_ack});
  endtask
  task automatic ident(input logic [7:0] exp);
    acc(1'b0, ufic_pkg::OFF_IDENT, 8'h00);
    check("ident", exp, rd);
  endtask
  // Offer one received byte, holding it until the queue has room
  task automatic push_rx(input logic [7:0] b);
    int n;
    @(negedge ref_clk);
    rx_valid = 1'b1;
    rx_data = b;
    for (n = 0; n < 50 && rx_ready !== 1'b1; n++)
      @(negedge ref_clk);
    if (n == 50)
    begin
      n_mismatch++;
      report_and_stop();
    end
    @(negedge ref_clk);
    rx_valid = 1'b0;
  endtask
  // Fill the transmit path while stalled, optionally flush, then drain
  task automatic tx_run(input int n, input logic fl, input int cnt);
    int j;
    sink_u.got.delete();
    stall = 1'b1;
    for (j = 0; j < n; j++)
      acc(1'b1, ufic_pkg::OFF_DATA, 8'h20 + 8'(j));
    if (fl)
      acc(1'b1, ufic_pkg::OFF_IDENT, 8'h05);
    stall = 1'b0;
    repeat (80) @(negedge ref_clk);
    check("tx count", 8'(cnt), 8'(sink_u.got.size()));
    for (j = 0; j < sink_u.got.size(); j++)
      check("tx byte", 8'h20 + 8'(j), sink_u.got[j]);
  endtask
  // Bound on the whole run so a hang still reaches the verdict
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    repeat (8) @(negedge ref_clk);
    arst_n = 1'b1;
    ident(8'h01);
    acc(1'b0, 3'h7, 8'h00);
    check("unmapped", 8'h00, rd);
    $display("test reset done");
    int_enable = 4'h1;
    for (k = 0; k < 4; k++)
    begin
      acc(1'b1, ufic_pkg::OFF_IDENT, {2'(k), 6'h0F});
      ident(8'hC1);
      for (i = 1; i < trig[k]; i++)
        push_rx(8'(i));
      ident(8'hC1);
      push_rx(8'(trig[k]));
      ident(8'hC4);
      acc(1'b0, ufic_pkg::OFF_DATA, 8'h00);
      check("rx head", 8'h01, rd);
      ident(8'hC1);
    end
    $display("test trigger done");
    repeat (4)
    begin
      @(negedge ref_clk);
      char_tick = 1'b1;
      @(negedge ref_clk);
      char_tick = 1'b0;
    end
    ident(8'hCC);
    acc(1'b0, ufic_pkg::OFF_DATA, 8'h00);
    ident(8'hC1);
    $display("test timeout done");
    acc(1'b1, ufic_pkg::OFF_IDENT, 8'h00);
    ident(8'h01);
    check("fifo mode", 8'h00, {7'h00, fifo_mode});
    push_rx(8'h77);
    check("rx room", 8'h00, {7'h00, rx_ready});
    ident(8'h04);
    acc(1'b0, ufic_pkg::OFF_DATA, 8'h00);
    check("rx byte", 8'h77, rd);
    acc(1'b1, ufic_pkg::OFF_IDENT, 8'h01);
    // Clock enable low: a disable write must be neither taken nor answered
    @(negedge ref_clk);
    ce = 1'b0;
    reg_addr = ufic_pkg::OFF_IDENT;
    reg_wdata = 8'h00;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    check("frozen ack", 8'h00, {7'h00, reg_ack});
    @(negedge ref_clk);
    ce = 1'b1;
    check("frozen mode", 8'h01, {7'h00, fifo_mode});
    $display("test disable done");
    slow = 1'b1;
    tx_run(20, 1'b0, 18);
    slow = 1'b0;
    tx_run(4, 1'b1, 2);
    $display("test transmit done");
    int_enable = 4'hF;
    acc(1'b1, ufic_pkg::OFF_DATA, 8'h5A);
    repeat (10) @(negedge ref_clk);
    line_err = 4'h1;
    modem_change = 4'h4;
    @(negedge ref_clk);
    line_err = 4'h0;
    modem_change = 4'h0;
    push_rx(8'h3C);
    ident(8'hC6);
    check("intr busy", 8'h01, {7'h00, intr_pending});
    acc(1'b0, ufic_pkg::OFF_LINE_STAT, 8'h00);
    ident(8'hC4);
    acc(1'b0, ufic_pkg::OFF_DATA, 8'h00);
    check("rx byte", 8'h3C, rd);
    ident(8'hC2);
    ident(8'hC0);
    acc(1'b0, ufic_pkg::OFF_MODEM_STAT, 8'h00);
    ident(8'hC1);
    check("intr idle", 8'h00, {7'h00, intr_pending});
    $display("test priority done");
    report_and_stop();
  end
endmodule
`default_nettype wire
